//--- rtl/lpv_pkg.sv
// package: register map, field layout, reset values and timing for the lane pattern verifier
package lpv_pkg;
  localparam int NUM_LANES = 4;
  localparam int CNT_W = 12;
  localparam int LFSR_W = 31;
  localparam logic [7:0] OFF_SYNC_LOAD = 8'h0E;
  localparam logic [7:0] OFF_FAIL_SEARCH = 8'h0F;
  localparam logic [7:0] OFF_MODE_CFG = 8'h10;
  localparam logic [7:0] OFF_CP_LOW = 8'h11;
  localparam logic [7:0] OFF_CP_MID = 8'h12;
  localparam logic [7:0] OFF_CP_HIGH = 8'h13;
  localparam logic [7:0] OFF_RETAIN = 8'h14;
  localparam logic [7:0] OFF_TEST_CTRL = 8'h15;
  localparam logic [7:0] OFF_DP_CTRL = 8'h16;
  localparam logic [7:0] OFF_TEST_FLAGS = 8'h17;
  localparam logic [7:0] OFF_CNT_BASE = 8'h18;
  localparam logic [7:0] OFF_CNT_LAST = 8'h1F;
  localparam logic [7:0] OFF_TIMEOUT = 8'h21;
  localparam int POS_CP20 = 7;
  localparam int POS_ALIGN_DONE = 7;
  localparam int POS_CNT_CLEAR = 4;
  localparam int POS_FLAG_CLEAR = 3;
  localparam logic [2:0] RST_FIELD3 = 3'h0;
  localparam logic [3:0] RST_NIBBLE = 4'h0;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_TIMEOUT = 3'h0;
  localparam logic [3:0] TIMING_PULSE_UI = 4'h8;
  localparam logic [15:0] LOCK_BASE_BITS = 16'h0010;
  localparam logic [4:0] CP_LAST_16 = 5'h0F;
  localparam logic [4:0] CP_LAST_20 = 5'h13;

  typedef enum logic [2:0] {
    PRBS7 = 3'h0, PRBS11 = 3'h1, PRBS23 = 3'h2, PRBS31 = 3'h3,
    PRBS15 = 3'h4, PRBS15B = 3'h5, PRBS20 = 3'h6, PRBS20B = 3'h7
  } lpv_len_t;

  typedef enum logic [2:0] {
    DPC_DISPARITY = 3'h0, DPC_FIFO_ERR = 3'h1, DPC_FIFO_OVF = 3'h2,
    DPC_FIFO_UDF = 3'h3, DPC_DESKEW = 3'h4
  } lpv_dpc_t;

  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_PRBS = 2'h1;
  localparam logic [1:0] MODE_CLOCK = 2'h2;
  localparam logic [1:0] MODE_CUSTOM = 2'h3;

  typedef struct packed {
    logic [2:0] timeout;
    logic [2:0] mode;
    logic [2:0] seq_len;
    logic custom_twenty;
    logic [19:0] pattern;
    logic [2:0] retain;
  } lpv_cfg_t;

  typedef struct packed {
    logic [3:0] disparity;
    logic [3:0] fifo_err;
    logic [3:0] fifo_ovf;
    logic [3:0] fifo_udf;
  } lpv_dp_t;
endpackage : lpv_pkg

//--- rtl/lpv_top.sv
// lane pattern verifier and bit-error counter, four receive lanes, byte-wide register port
`timescale 1ns/1ns
module lpv_top (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic [3:0] LANE_RX_BIT,
  input wire logic [3:0] LANE_RX_VALID,
  input wire lpv_pkg::lpv_dp_t DP_STATUS,
  input wire logic LANE_ALIGN_DONE,
  output logic [3:0] LANE_TIMING_PULSE
);

  localparam int NL = lpv_pkg::NUM_LANES;

  // last count of the sequence period, 2^n - 2, for a period of 2^n - 1 bits
  function automatic logic [30:0] seq_period(input logic [2:0] len);
    logic [30:0] p;
    p = 31'h0000007F;
    unique case (lpv_pkg::lpv_len_t'(len))
      lpv_pkg::PRBS7: p = 31'h0000007F;
      lpv_pkg::PRBS11: p = 31'h000007FF;
      lpv_pkg::PRBS23: p = 31'h007FFFFF;
      lpv_pkg::PRBS31: p = 31'h7FFFFFFF;
      lpv_pkg::PRBS15, lpv_pkg::PRBS15B: p = 31'h00007FFF;
      lpv_pkg::PRBS20, lpv_pkg::PRBS20B: p = 31'h000FFFFF;
    endcase
    return p - 31'h00000001;
  endfunction : seq_period

  // predicted next bit from the received history, bit 0 newest
  function automatic logic prbs_predict(input logic [30:0] s, input logic [2:0] len);
    logic b;
    b = 1'b0;
    unique case (lpv_pkg::lpv_len_t'(len))
      lpv_pkg::PRBS7: b = s[6] ^ s[5];
      lpv_pkg::PRBS11: b = s[10] ^ s[8];
      lpv_pkg::PRBS23: b = s[22] ^ s[17];
      lpv_pkg::PRBS31: b = s[30] ^ s[27];
      lpv_pkg::PRBS15, lpv_pkg::PRBS15B: b = s[14] ^ s[13];
      lpv_pkg::PRBS20, lpv_pkg::PRBS20B: b = s[19] ^ s[2];
    endcase
    return b;
  endfunction : prbs_predict

  function automatic logic [11:0] sat_inc(input logic [11:0] c);
    return (c == 12'hFFF) ? c : c + 12'h001;
  endfunction : sat_inc

  // software-facing registers
  logic [3:0] load_reg;
  logic [2:0] mode_reg;
  logic [2:0] len_reg;
  logic cp20_reg;
  logic [19:0] cp_reg;
  logic [2:0] retain_reg;
  logic [2:0] timeout_reg;
  logic cnt_clear_reg;
  logic cnt_clear_seen_reg;
  logic flag_clear_reg;
  logic [2:0] test_sel_reg;
  logic [3:0] dp_en_reg;
  logic [2:0] dp_sel_reg;
  logic align_done_reg;

  // per-lane state
  lpv_pkg::lpv_cfg_t cfg_reg [NL];
  logic [30:0] hist_reg [NL];
  logic [30:0] period_reg [NL];
  logic [3:0] pulse_cnt_reg [NL];
  logic [4:0] cp_idx_reg [NL];
  logic [15:0] good_reg [NL];
  logic [2:0] bad_run_reg [NL];
  logic [3:0] locked_reg;
  logic [3:0] fail_reg;
  logic [3:0] live_reg;
  logic [3:0] latched_reg;
  logic [11:0] cnt_reg [NL];

  lpv_pkg::lpv_cfg_t cur_cfg;
  logic [3:0] exp_bit;
  logic [3:0] checking;
  logic [3:0] bit_err;
  logic [3:0] live_next;
  logic dp_cond;
  logic dp_active;

  assign cur_cfg = '{timeout: timeout_reg, mode: mode_reg, seq_len: len_reg, custom_twenty: cp20_reg,
                     pattern: cp_reg, retain: retain_reg};
  assign dp_active = |dp_en_reg;

  logic wr_hit_test;
  assign wr_hit_test = REG_WR && (REG_ADDR == lpv_pkg::OFF_TEST_CTRL);

  // plain read/write fields
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      load_reg <= lpv_pkg::RST_NIBBLE;
      mode_reg <= lpv_pkg::RST_FIELD3;
      len_reg <= lpv_pkg::RST_FIELD3;
      cp20_reg <= 1'b0;
      cp_reg <= 20'h00000;
      retain_reg <= lpv_pkg::RST_FIELD3;
      timeout_reg <= lpv_pkg::RST_TIMEOUT;
      test_sel_reg <= lpv_pkg::RST_FIELD3;
      dp_en_reg <= lpv_pkg::RST_NIBBLE;
      dp_sel_reg <= lpv_pkg::RST_FIELD3;
    end else if (REG_WR) begin
      unique case (REG_ADDR)
        lpv_pkg::OFF_SYNC_LOAD: load_reg <= REG_WDATA[3:0];
        lpv_pkg::OFF_MODE_CFG: begin
          cp20_reg <= REG_WDATA[lpv_pkg::POS_CP20];
          len_reg <= REG_WDATA[5:3];
          mode_reg <= REG_WDATA[2:0];
        end
        lpv_pkg::OFF_CP_LOW: cp_reg[7:0] <= REG_WDATA;
        lpv_pkg::OFF_CP_MID: cp_reg[15:8] <= REG_WDATA;
        lpv_pkg::OFF_CP_HIGH: cp_reg[19:16] <= REG_WDATA[3:0];
        lpv_pkg::OFF_RETAIN: retain_reg <= REG_WDATA[2:0];
        lpv_pkg::OFF_TIMEOUT: timeout_reg <= REG_WDATA[2:0];
        lpv_pkg::OFF_TEST_CTRL: test_sel_reg <= REG_WDATA[2:0];
        lpv_pkg::OFF_DP_CTRL: begin
          dp_en_reg <= REG_WDATA[7:4];
          dp_sel_reg <= REG_WDATA[2:0];
        end
        default: ;
      endcase
    end
  end

  // clear bits: set by a write of one, drop back the cycle after acting
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      cnt_clear_reg <= 1'b0;
      cnt_clear_seen_reg <= 1'b0;
      flag_clear_reg <= 1'b0;
    end else begin
      cnt_clear_seen_reg <= cnt_clear_reg;
      cnt_clear_reg <= wr_hit_test && REG_WDATA[lpv_pkg::POS_CNT_CLEAR] && !cnt_clear_reg;
      flag_clear_reg <= wr_hit_test && REG_WDATA[lpv_pkg::POS_FLAG_CLEAR] && !flag_clear_reg;
    end
  end

  // alignment state from the deskew logic
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      align_done_reg <= 1'b0;
    end else begin
      align_done_reg <= LANE_ALIGN_DONE;
    end
  end

  // settings follow the registers only while the load bit is high
  always_ff @(posedge CLK_SYS) begin
    for (int n = 0; n < NL; n++) begin
      if (RESET) begin
        cfg_reg[n] <= '0;
      end else if (load_reg[n]) begin
        cfg_reg[n] <= cur_cfg;
      end
    end
  end

  // expected bit and error detection per lane
  always_comb begin
    for (int n = 0; n < NL; n++) begin
      exp_bit[n] = 1'b0;
      checking[n] = 1'b0;
      if (!cfg_reg[n].mode[2]) begin
        unique case (cfg_reg[n].mode[1:0])
          lpv_pkg::MODE_OFF: checking[n] = 1'b0;
          lpv_pkg::MODE_PRBS: begin
            checking[n] = 1'b1;
            exp_bit[n] = prbs_predict(hist_reg[n], cfg_reg[n].seq_len);
          end
          lpv_pkg::MODE_CLOCK: begin
            checking[n] = 1'b1;
            exp_bit[n] = ~hist_reg[n][0];
          end
          lpv_pkg::MODE_CUSTOM: begin
            checking[n] = 1'b1;
            // upper four bits only reachable in twenty-bit mode
            exp_bit[n] = cfg_reg[n].pattern[cp_idx_reg[n]];
          end
        endcase
      end
      bit_err[n] = checking[n] && LANE_RX_VALID[n] && (LANE_RX_BIT[n] != exp_bit[n]);
    end
  end

  // period counter and 8-bit-time timing pulse
  always_ff @(posedge CLK_SYS) begin
    for (int n = 0; n < NL; n++) begin
      if (RESET || cfg_reg[n].mode == 3'h0) begin
        period_reg[n] <= 31'h00000000;
        pulse_cnt_reg[n] <= 4'h0;
        LANE_TIMING_PULSE[n] <= 1'b0;
      end else if (LANE_RX_VALID[n]) begin
        if (period_reg[n] >= seq_period(cfg_reg[n].seq_len)) begin
          period_reg[n] <= 31'h00000000;
          pulse_cnt_reg[n] <= lpv_pkg::TIMING_PULSE_UI;
          LANE_TIMING_PULSE[n] <= 1'b1;
        end else begin
          period_reg[n] <= period_reg[n] + 31'h00000001;
          if (pulse_cnt_reg[n] > 4'h1) begin
            pulse_cnt_reg[n] <= pulse_cnt_reg[n] - 4'h1;
          end else begin
            pulse_cnt_reg[n] <= 4'h0;
            LANE_TIMING_PULSE[n] <= 1'b0;
          end
        end
      end
    end
  end

  // history shift and custom index; a miss during search slips the custom index one place
  always_ff @(posedge CLK_SYS) begin
    for (int n = 0; n < NL; n++) begin
      if (RESET) begin
        hist_reg[n] <= 31'h00000000;
        cp_idx_reg[n] <= 5'h00;
      end else if (LANE_RX_VALID[n]) begin
        hist_reg[n] <= {hist_reg[n][29:0], LANE_RX_BIT[n]};
        // index wraps at 16 or 20
        if (cp_idx_reg[n] >= (cfg_reg[n].custom_twenty ? lpv_pkg::CP_LAST_20 : lpv_pkg::CP_LAST_16)) begin
          cp_idx_reg[n] <= 5'h00;
        end else if (!(bit_err[n] && !locked_reg[n])) begin
          cp_idx_reg[n] <= cp_idx_reg[n] + 5'h01;
        end
      end
    end
  end

  // lock: 16<<timeout clean bits to lock, retain+1 errors in a row to lose it
  always_ff @(posedge CLK_SYS) begin
    for (int n = 0; n < NL; n++) begin
      if (RESET || !checking[n] || load_reg[n]) begin
        good_reg[n] <= 16'h0000;
        bad_run_reg[n] <= 3'h0;
        locked_reg[n] <= 1'b0;
      end else if (LANE_RX_VALID[n]) begin
        if (!locked_reg[n]) begin
          good_reg[n] <= bit_err[n] ? 16'h0000 : good_reg[n] + 16'h0001;
          if (!bit_err[n] && good_reg[n] + 16'h0001 >= (lpv_pkg::LOCK_BASE_BITS << cfg_reg[n].timeout)) begin
            locked_reg[n] <= 1'b1;
          end
        end else if (bit_err[n]) begin
          if (bad_run_reg[n] >= cfg_reg[n].retain) begin
            locked_reg[n] <= 1'b0;
            good_reg[n] <= 16'h0000;
            bad_run_reg[n] <= 3'h0;
          end else begin
            bad_run_reg[n] <= bad_run_reg[n] + 3'h1;
          end
        end else begin
          bad_run_reg[n] <= 3'h0;
        end
      end
    end
  end

  // mismatch flag is sticky until the lane is reloaded
  always_ff @(posedge CLK_SYS) begin
    for (int n = 0; n < NL; n++) begin
      if (RESET) begin
        fail_reg[n] <= 1'b0;
      end else if (bit_err[n] && locked_reg[n]) begin
        fail_reg[n] <= 1'b1;
      end else if (load_reg[n]) begin
        fail_reg[n] <= 1'b0;
      end
    end
  end

  // datapath condition, reserved codes report nothing
  always_comb begin
    dp_cond = 1'b0;
    case (dp_sel_reg)
      lpv_pkg::DPC_DISPARITY: dp_cond = |(DP_STATUS.disparity & dp_en_reg);
      lpv_pkg::DPC_FIFO_ERR: dp_cond = |(DP_STATUS.fifo_err & dp_en_reg);
      lpv_pkg::DPC_FIFO_OVF: dp_cond = |(DP_STATUS.fifo_ovf & dp_en_reg);
      lpv_pkg::DPC_FIFO_UDF: dp_cond = |(DP_STATUS.fifo_udf & dp_en_reg);
      lpv_pkg::DPC_DESKEW: dp_cond = align_done_reg;
      default: dp_cond = 1'b0;
    endcase
  end

  // source 0 mismatch events, 1 searching, 2 timing pulse, else quiet
  always_comb begin
    for (int n = 0; n < NL; n++) begin
      unique case (test_sel_reg)
        3'h0: live_next[n] = bit_err[n] && locked_reg[n];
        3'h1: live_next[n] = checking[n] && !locked_reg[n];
        3'h2: live_next[n] = LANE_TIMING_PULSE[n];
        default: live_next[n] = 1'b0;
      endcase
    end
    // datapath condition takes over lane 0
    if (dp_active) begin
      live_next[0] = dp_cond;
    end
  end

  // latched flags; a new event wins over a clear in the same cycle
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      live_reg <= 4'h0;
      latched_reg <= 4'h0;
    end else begin
      live_reg <= live_next;
      latched_reg <= (flag_clear_reg ? 4'h0 : latched_reg) | live_next;
    end
  end

  // saturating counters, cleared on the clear bit's rising edge
  always_ff @(posedge CLK_SYS) begin
    for (int n = 0; n < NL; n++) begin
      if (RESET || (cnt_clear_reg && !cnt_clear_seen_reg)) begin
        cnt_reg[n] <= 12'h000;
      end else if (dp_active) begin
        // pattern counts frozen, lane 0 counts datapath events
        if (n == 0 && dp_cond) begin
          cnt_reg[n] <= sat_inc(cnt_reg[n]);
        end
      end else if (bit_err[n] && locked_reg[n]) begin
        cnt_reg[n] <= sat_inc(cnt_reg[n]);
      end
    end
  end

  // registered read port, unmapped addresses read zero
  always_ff @(posedge CLK_SYS) begin
    if (RESET) begin
      REG_RDATA <= lpv_pkg::RST_BYTE;
      REG_RVALID <= 1'b0;
    end else begin
      REG_RVALID <= REG_RD;
      REG_RDATA <= lpv_pkg::RST_BYTE;
      if (REG_RD) begin
        case (REG_ADDR)
          lpv_pkg::OFF_SYNC_LOAD: REG_RDATA <= {LANE_TIMING_PULSE, load_reg};
          lpv_pkg::OFF_FAIL_SEARCH: REG_RDATA <= {fail_reg, checking & ~locked_reg};
          lpv_pkg::OFF_MODE_CFG: REG_RDATA <= {cp20_reg, 1'b0, len_reg, mode_reg};
          lpv_pkg::OFF_CP_LOW: REG_RDATA <= cp_reg[7:0];
          lpv_pkg::OFF_CP_MID: REG_RDATA <= cp_reg[15:8];
          lpv_pkg::OFF_CP_HIGH: REG_RDATA <= {4'h0, cp_reg[19:16]};
          lpv_pkg::OFF_RETAIN: REG_RDATA <= {5'h00, retain_reg};
          lpv_pkg::OFF_TIMEOUT: REG_RDATA <= {5'h00, timeout_reg};
          lpv_pkg::OFF_TEST_CTRL: REG_RDATA <= {align_done_reg, 2'h0, cnt_clear_reg, flag_clear_reg, test_sel_reg};
          lpv_pkg::OFF_DP_CTRL: REG_RDATA <= {dp_en_reg, 1'b0, dp_sel_reg};
          lpv_pkg::OFF_TEST_FLAGS: REG_RDATA <= {latched_reg, live_reg};
          default: begin
            if (REG_ADDR >= lpv_pkg::OFF_CNT_BASE && REG_ADDR <= lpv_pkg::OFF_CNT_LAST) begin
              REG_RDATA <= REG_ADDR[0] ? {4'h0, cnt_reg[REG_ADDR[2:1]][11:8]} : cnt_reg[REG_ADDR[2:1]][7:0];
            end
          end
        endcase
      end
    end
  end

endmodule : lpv_top

//--- verif/lpv_src.sv
// partner: serial source sending a PRBS7 stream on one lane, with single-bit error injection
`timescale 1ns/1ns
module lpv_src (
  input wire logic clk,
  input wire logic inject,
  output logic rx_bit,
  output logic rx_valid
);
  logic [6:0] lfsr_reg = 7'h7F;
  always @(negedge clk) lfsr_reg <= {lfsr_reg[5:0], lfsr_reg[6] ^ lfsr_reg[5]};
  assign rx_bit = lfsr_reg[0] ^ inject;
  // continuous stream keeps the pulse spacing a fixed number of clocks
  assign rx_valid = 1'b1;
endmodule : lpv_src

//--- verif/lpv_sva.sv
// checker: register port and timing pulse properties of the lane pattern verifier
`timescale 1ns/1ns
module lpv_sva (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic [3:0] LANE_RX_BIT,
  input wire logic [3:0] LANE_RX_VALID,
  input wire lpv_pkg::lpv_dp_t DP_STATUS,
  input wire logic LANE_ALIGN_DONE,
  input wire logic [3:0] LANE_TIMING_PULSE
);
  logic [7:0] gap_reg;
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  // cycles since lane 0 pulse start; a load write may restart the sequence, so the gap becomes unusable
  always_ff @(posedge CLK_SYS) begin
    if (RESET || (REG_WR && REG_ADDR == lpv_pkg::OFF_SYNC_LOAD)) gap_reg <= 8'hFF;
    else if ($rose(LANE_TIMING_PULSE[0])) gap_reg <= 8'h00;
    else if (gap_reg != 8'hFF) gap_reg <= gap_reg + 8'h01;
  end
  rd_answer_a: assert property (REG_RD |=> REG_RVALID)
    else $error("read not answered after one cycle");
  rdata_quiet_a: assert property (!REG_RVALID |-> REG_RDATA == 8'h00)
    else $error("read data not zero outside answer");
  cnt_resv_a: assert property (REG_RD && REG_ADDR == 8'h19 |=> REG_RDATA[7:4] == 4'h0)
    else $error("counter high byte upper nibble not zero");
  cfg_resv_a: assert property (REG_RD && REG_ADDR == 8'h10 |=> !REG_RDATA[6])
    else $error("mode register reserved bit set");
  align_done_a: assert property (REG_RD && REG_ADDR == 8'h15 |=> REG_RDATA[7] == $past(LANE_ALIGN_DONE, 2))
    else $error("alignment bit does not follow input");
  pulse_width_a: assert property ($rose(LANE_TIMING_PULSE[0]) |-> LANE_TIMING_PULSE[0][*8] ##1 !LANE_TIMING_PULSE[0])
    else $error("timing pulse not eight bits long");
  pulse_period_a: assert property ($rose(LANE_TIMING_PULSE[0]) && gap_reg != 8'hFF |-> gap_reg == 8'h7E)
    else $error("timing pulse period not 127 bits");
  cnt_clear_a: assert property (REG_WR && REG_ADDR == 8'h15 && REG_WDATA[4] ##2 REG_RD && REG_ADDR == 8'h18
    |=> REG_RDATA == 8'h00)
    else $error("counter not zero after clear");
  pulse_seen_c: cover property ($rose(LANE_TIMING_PULSE[0]));
  cnt_read_c: cover property (REG_RD && REG_ADDR == 8'h18);
  clear_wr_c: cover property (REG_WR && REG_ADDR == 8'h15 && REG_WDATA[4]);
endmodule : lpv_sva

bind lpv_top lpv_sva i_sva (.CLK_SYS(CLK_SYS), .RESET(RESET), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .LANE_RX_BIT(LANE_RX_BIT),
  .LANE_RX_VALID(LANE_RX_VALID), .DP_STATUS(DP_STATUS), .LANE_ALIGN_DONE(LANE_ALIGN_DONE),
  .LANE_TIMING_PULSE(LANE_TIMING_PULSE));

//--- verif/lpv_top_tb.sv
// testbench: register-level checks of the lane pattern verifier with a PRBS7 lane source
`timescale 1ns/1ns
module lpv_top_tb;
  logic clk_sys;
  logic reset;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic reg_rvalid;
  lpv_pkg::lpv_dp_t dp_status;
  logic align_done;
  logic [3:0] timing_pulse;
  logic inject;
  logic src_bit;
  logic src_valid;
  int bad_count = 0;
  int check_count = 0;
  int cycles = 0;
  logic [7:0] wa [0:9] = '{8'h0F, 8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h21};
  logic [7:0] we [0:9] = '{8'h00, 8'hBF, 8'hFF, 8'hFF, 8'h0F, 8'h07, 8'h07, 8'hF7, 8'h00, 8'h07};

  lpv_top i_dut (.CLK_SYS(clk_sys), .RESET(reset), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(reg_rdata), .REG_RVALID(reg_rvalid), .LANE_RX_BIT({3'h0, src_bit}),
    .LANE_RX_VALID({3'h0, src_valid}), .DP_STATUS(dp_status), .LANE_ALIGN_DONE(align_done),
    .LANE_TIMING_PULSE(timing_pulse));
  lpv_src i_src (.clk(clk_sys), .inject(inject), .rx_bit(src_bit), .rx_valid(src_valid));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // wr and rd are entered just after a falling edge and leave one falling edge later
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_rd = 1'b0;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_wr = 1'b0;
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys);
    check("read valid", 8'h01, {7'h00, reg_rvalid});
    check($sformatf("register %h", a), exp, reg_rdata);
  endtask : rd

  task automatic nop(input int n);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (n) @(negedge clk_sys);
  endtask : nop

  task automatic flip;
    // strobes off so a preceding access is not repeated while the error goes in
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    inject = 1'b1;
    @(negedge clk_sys);
    inject = 1'b0;
    nop(20);
  endtask : flip

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  // ceiling well above the longest scenario, the saturation run
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 9000) begin
      bad_count++;
      print_verdict();
    end
  end

  initial begin
    reset = 1'b1;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    dp_status = '0;
    align_done = 1'b0;
    inject = 1'b0;
    repeat (16) @(negedge clk_sys);
    reset = 1'b0;
    for (int a = 8'h0D; a <= 8'h22; a++) rd(8'(a), 8'h00);
    foreach (wa[i]) wr(wa[i], 8'hFF);
    nop(2);
    foreach (wa[i]) rd(wa[i], we[i]);
    foreach (wa[i]) wr(wa[i], 8'h00);
    wr(8'h14, 8'h07);
    wr(8'h0E, 8'h01);
    wr(8'h10, 8'h01);
    wr(8'h0E, 8'h00);
    wr(8'h10, 8'h00);
    rd(8'h0F, 8'h01);
    nop(60);
    rd(8'h0F, 8'h00);
    flip();
    flip();
    rd(8'h0F, 8'h10);
    rd(8'h18, 8'h06);
    rd(8'h19, 8'h00);
    rd(8'h17, 8'h10);
    wr(8'h15, 8'h08);
    nop(2);
    rd(8'h17, 8'h00);
    wr(8'h15, 8'h10);
    // counters clear one edge after the clear bit rises, so the read waits a cycle
    nop(1);
    rd(8'h18, 8'h00);
    rd(8'h15, 8'h00);
    for (int c = 0; c < 5; c++) begin
      wr(8'h16, 8'h10 | 8'(c));
      wr(8'h15, 8'h10);
      nop(2);
      dp_status = (c < 4) ? (16'h1000 >> (4 * c)) : 16'h0000;
      align_done = (c == 4);
      nop(5);
      dp_status = '0;
      align_done = 1'b0;
      nop(3);
      rd(8'h18, 8'h05);
    end
    wr(8'h16, 8'h10);
    wr(8'h15, 8'h10);
    nop(2);
    dp_status = 16'h1000;
    nop(10);
    rd(8'h17, 8'h11);
    nop(4190);
    dp_status = '0;
    nop(2);
    rd(8'h18, 8'hFF);
    rd(8'h19, 8'h0F);
    rd(8'h17, 8'h10);
    wr(8'h16, 8'h00);
    align_done = 1'b1;
    nop(3);
    rd(8'h15, 8'h80);
    align_done = 1'b0;
    wr(8'h10, 8'h04);
    wr(8'h0E, 8'h01);
    wr(8'h0E, 8'h00);
    wr(8'h15, 8'h10);
    flip();
    rd(8'h18, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr(8'h10, 8'((i << 3) | i));
      wr(8'h0E, 8'h02);
      wr(8'h0E, 8'h00);
      rd(8'h10, 8'((i << 3) | i));
    end
    nop(4);
    print_verdict();
  end
endmodule : lpv_top_tb
